// >>> src/ldp_dma_front.sv
// module: register front end and status of the descriptor dma engine
// Operation
// [RULE1] any write to tx poll while tx suspended requests a tx descriptor fetch; the code requests none while bus access is halted after a fault
// [RULE2] software writes tx poll only while tx is suspended
// [RULE3] any write to rx poll while rx suspended requests an rx descriptor fetch; the code requests none while bus access is halted after a fault
// [RULE4] software writes rx poll only while rx is suspended
// [RULE5] rx ring base keeps bits 31..2, bits 1..0 read as zero
// [RULE6] software changes rx ring base only while rx is stopped
// [RULE7] tx ring base keeps bits 31..2, bits 1..0 read as zero
// [RULE8] software changes tx ring base only while tx is stopped
// [RULE9] fault kind field is valid only with fatal flag, never interrupts
// [RULE10] fault kind codes: parity 000, master abort 001, target abort 010
// [RULE11] status bits 22..20 show the tx state, no interrupt
// [RULE12] status bits 19..17 show the rx state, no interrupt
// [RULE13] normal summary bit 16 set by bits 0, 2, 6 or secondary bit 16
// [RULE14] abnormal summary bit 15 set by abnormal bits or secondary bit 15
// [RULE15] bus fault sets fatal bit 13 and stops all bus master access
// [RULE16] after a fatal fault only soft reset restores bus access
// [RULE17] latched flags stay high until software writes one to them
// [RULE18] after reset state fields, fault kind and flags read zero
`timescale 1ns/100ps
module ldp_dma_front
  import ldp_pkg::*;
(
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite write address and data
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  // axi4-lite write response
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // axi4-lite read
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // engine side
  input  wire logic        soft_reset_bit,
  input  wire logic [2:0]  tx_engine_state,
  input  wire logic [2:0]  rx_engine_state,
  input  wire logic [11:0] event_pulse,
  input  wire logic        sec_normal_sum,
  input  wire logic        sec_abnormal_sum,
  input  wire logic        bus_fault,
  input  wire logic [2:0]  bus_fault_kind_in,
  // engine controls
  output logic             tx_fetch_req,
  output logic             rx_fetch_req,
  output logic             bus_master_en,
  output logic [29:0]      tx_ring_start,
  output logic [29:0]      rx_ring_start,
  // interrupt
  output logic             irq
);
  // ==========================================================
  // state
  logic [7:0]  aw_addr, next_aw_addr;
  logic        aw_held, next_aw_held;
  logic [31:0] w_data, next_w_data;
  logic [3:0]  w_strb, next_w_strb;
  logic        w_held, next_w_held;
  logic        b_valid, next_b_valid;
  logic [1:0]  b_resp, next_b_resp;
  logic        r_valid, next_r_valid;
  logic [1:0]  r_resp, next_r_resp;
  logic [31:0] r_data, next_r_data;
  logic [31:0] tx_poll_value, next_tx_poll_value;
  logic [31:0] rx_poll_value, next_rx_poll_value;
  logic [29:0] next_tx_ring_start, next_rx_ring_start;
  logic [11:0] ev_flags, next_ev_flags;
  logic        normal_event_summary, next_normal_event_summary;
  logic        abnormal_event_summary, next_abnormal_event_summary;
  logic        fatal_bus_fault, next_fatal_bus_fault;
  logic [2:0]  bus_fault_kind, next_bus_fault_kind;
  logic [2:0]  tx_state, next_tx_state;
  logic [2:0]  rx_state, next_rx_state;
  logic [15:0] int_mask, next_int_mask;
  logic        tx_req, next_tx_req;
  logic        rx_req, next_rx_req;
  logic        bus_halt, next_bus_halt;
  logic        do_write;
  logic [31:0] wmask;
  logic [31:0] wclr;
  logic [31:0] status_word;
  logic        hit_w;
  // ==========================================================
  // helpers
  function automatic logic [31:0] strb_mask(input logic [3:0] s);
    strb_mask = {{8{s[3]}}, {8{s[2]}}, {8{s[1]}}, {8{s[0]}}};
  endfunction : strb_mask

  // status word as software reads it
  assign status_word = {6'h00, bus_fault_kind, tx_state, rx_state,
                        normal_event_summary, abnormal_event_summary,
                        1'b0, fatal_bus_fault, 1'b0, ev_flags};
  assign do_write = aw_held && w_held && !b_valid;
  assign wmask    = strb_mask(w_strb);
  assign wclr     = w_data & wmask;

  // ==========================================================
  // axi channel handshakes
  assign awready = !aw_held;
  assign wready  = !w_held;
  assign arready = !r_valid;
  assign bvalid  = b_valid;
  assign bresp   = b_resp;
  assign rvalid  = r_valid;
  assign rresp   = r_resp;
  assign rdata   = r_data;
  assign tx_fetch_req  = tx_req;
  assign rx_fetch_req  = rx_req;
  assign bus_master_en = !bus_halt; // RULE15 RULE16
  // bit 16 has no mask bit, so only bits 15..0 can interrupt
  assign irq = |(status_word[15:0] & int_mask);

  // next values of bus slave and registers
  always_comb begin
    next_aw_addr = aw_addr;
    next_aw_held = aw_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_w_held  = w_held;
    next_b_valid = b_valid;
    next_b_resp  = b_resp;
    next_r_valid = r_valid;
    next_r_resp  = r_resp;
    next_r_data  = r_data;
    next_tx_poll_value = tx_poll_value;
    next_rx_poll_value = rx_poll_value;
    next_tx_ring_start = tx_ring_start;
    next_rx_ring_start = rx_ring_start;
    next_int_mask = int_mask;
    next_tx_req = 1'b0;
    next_rx_req = 1'b0;
    hit_w = 1'b1;
    if (awvalid && !aw_held) begin
      next_aw_addr = awaddr;
      next_aw_held = 1'b1;
    end
    if (wvalid && !w_held) begin
      next_w_data = wdata;
      next_w_strb = wstrb;
      next_w_held = 1'b1;
    end
    if (b_valid && bready) begin
      next_b_valid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_b_valid = 1'b1;
      case (aw_addr)
        ADDR_TX_POLL_KICK: begin
          next_tx_poll_value = (tx_poll_value & ~wmask) | wclr;
          // kick honoured only in suspended state, never while bus access is halted
          next_tx_req = (tx_state == TX_SUSP) && !bus_halt; // RULE1
        end
        ADDR_RX_POLL_KICK: begin
          next_rx_poll_value = (rx_poll_value & ~wmask) | wclr;
          next_rx_req = (rx_state == RX_SUSP) && !bus_halt; // RULE3
        end
        ADDR_RX_RING_BASE: begin
          // bits 1..0 are not stored
          next_rx_ring_start = (rx_ring_start & ~wmask[31:2])
                               | wclr[31:2]; // RULE5
        end
        ADDR_TX_RING_BASE: begin
          next_tx_ring_start = (tx_ring_start & ~wmask[31:2])
                               | wclr[31:2]; // RULE7
        end
        ADDR_DMA_STATUS: begin
          hit_w = 1'b1;
        end
        ADDR_INT_MASK: begin
          next_int_mask = (int_mask & ~wmask[15:0]) | wclr[15:0];
        end
        default: begin
          hit_w = 1'b0;
        end
      endcase
      next_b_resp = hit_w ? RESP_OKAY : RESP_SLVERR;
    end
    if (r_valid && rready) begin
      next_r_valid = 1'b0;
    end
    if (arvalid && !r_valid) begin
      next_r_valid = 1'b1;
      next_r_resp  = RESP_OKAY;
      case (araddr)
        ADDR_TX_POLL_KICK: next_r_data = tx_poll_value;
        ADDR_RX_POLL_KICK: next_r_data = rx_poll_value;
        ADDR_RX_RING_BASE: next_r_data = {rx_ring_start, RING_ALIGN}; // RULE5
        ADDR_TX_RING_BASE: next_r_data = {tx_ring_start, RING_ALIGN}; // RULE7
        ADDR_DMA_STATUS:   next_r_data = status_word;
        ADDR_INT_MASK:     next_r_data = {16'h0000, int_mask};
        default: begin
          next_r_data = ZERO32;
          next_r_resp = RESP_SLVERR;
        end
      endcase
    end
  end

  // next values of the status register; a set wins over a clear
  always_comb begin
    logic status_wr;
    status_wr = do_write && (aw_addr == ADDR_DMA_STATUS);
    next_tx_state = tx_engine_state; // RULE11
    next_rx_state = rx_engine_state; // RULE12
    next_ev_flags = ev_flags;
    next_normal_event_summary   = normal_event_summary;
    next_abnormal_event_summary = abnormal_event_summary;
    next_fatal_bus_fault = fatal_bus_fault;
    next_bus_fault_kind  = bus_fault_kind;
    next_bus_halt        = bus_halt;
    if (status_wr) begin
      next_ev_flags = ev_flags & ~wclr[EV_W-1:0]; // RULE17
      if (wclr[NSUM_BIT]) next_normal_event_summary = 1'b0; // RULE17
      if (wclr[ASUM_BIT]) next_abnormal_event_summary = 1'b0; // RULE17
      if (wclr[FBE_BIT]) next_fatal_bus_fault = 1'b0; // RULE17
    end
    next_ev_flags = next_ev_flags | (event_pulse & EV_MASK);
    // a fault sets the flag even in a clearing cycle; bus stays halted
    if (bus_fault) begin
      next_fatal_bus_fault = 1'b1; // RULE15
      next_bus_halt        = 1'b1; // RULE15
    end
    // first fault latches its kind; later faults leave the kind unchanged
    if (bus_fault && !bus_halt) begin
      next_bus_fault_kind = bus_fault_kind_in; // RULE10
    end
    // summaries follow the updated flags so a full clear leaves none
    if (|(next_ev_flags & NORM_MASK) || sec_normal_sum) begin
      next_normal_event_summary = 1'b1; // RULE13
    end
    if (|(next_ev_flags & ABN_MASK) || next_fatal_bus_fault
        || sec_abnormal_sum) begin
      next_abnormal_event_summary = 1'b1; // RULE14
    end
  end

  // register bus slave and register state; only hardware reset clears it
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_addr <= 8'h00;
      aw_held <= 1'b0;
      w_data  <= ZERO32;
      w_strb  <= 4'h0;
      w_held  <= 1'b0;
      b_valid <= 1'b0;
      b_resp  <= RESP_OKAY;
      r_valid <= 1'b0;
      r_resp  <= RESP_OKAY;
      r_data  <= ZERO32;
      tx_ring_start <= 30'h0000_0000;
      rx_ring_start <= 30'h0000_0000;
      int_mask <= 16'h0000;
    end else begin
      aw_addr <= next_aw_addr;
      aw_held <= next_aw_held;
      w_data  <= next_w_data;
      w_strb  <= next_w_strb;
      w_held  <= next_w_held;
      b_valid <= next_b_valid;
      b_resp  <= next_b_resp;
      r_valid <= next_r_valid;
      r_resp  <= next_r_resp;
      r_data  <= next_r_data;
      tx_ring_start <= next_tx_ring_start;
      rx_ring_start <= next_rx_ring_start;
      int_mask <= next_int_mask;
    end
  end

  // engine facing state; soft reset also restores bus access
  always_ff @(posedge aclk) begin
    if (!aresetn || soft_reset_bit) begin
      tx_poll_value <= POLL_RESET;
      rx_poll_value <= POLL_RESET;
      tx_req   <= 1'b0;
      rx_req   <= 1'b0;
      ev_flags <= 12'h000; // RULE18
      normal_event_summary   <= 1'b0;
      abnormal_event_summary <= 1'b0;
      fatal_bus_fault <= 1'b0; // RULE16
      bus_fault_kind  <= FLT_PARITY;
      bus_halt        <= 1'b0; // RULE16
      tx_state <= TX_STOP;
      rx_state <= RX_STOP;
    end else begin
      tx_poll_value <= next_tx_poll_value;
      rx_poll_value <= next_rx_poll_value;
      tx_req   <= next_tx_req;
      rx_req   <= next_rx_req;
      ev_flags <= next_ev_flags;
      normal_event_summary   <= next_normal_event_summary;
      abnormal_event_summary <= next_abnormal_event_summary;
      fatal_bus_fault <= next_fatal_bus_fault;
      bus_fault_kind  <= next_bus_fault_kind;
      bus_halt        <= next_bus_halt;
      tx_state <= next_tx_state;
      rx_state <= next_rx_state;
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn || soft_reset_bit);

  chk_tx_kick_fetch: assert property ( // RULE1
    do_write && aw_addr == ADDR_TX_POLL_KICK && tx_state == TX_SUSP
    && bus_master_en |=> tx_fetch_req)
    else $error("tx kick in suspend gave no fetch");
  chk_tx_kick_ignored: assert property ( // RULE1
    tx_fetch_req |-> $past(tx_state) == TX_SUSP)
    else $error("tx fetch outside suspend");
  chk_rx_kick_fetch: assert property ( // RULE3
    rx_fetch_req |-> $past(rx_state) == RX_SUSP
    && $past(aw_addr) == ADDR_RX_POLL_KICK && $past(do_write))
    else $error("rx fetch without kick in suspend");
  chk_ring_align: assert property ( // RULE5
    rvalid && $rose(rvalid) && ($past(araddr) == ADDR_RX_RING_BASE
    || $past(araddr) == ADDR_TX_RING_BASE) |-> rdata[1:0] == RING_ALIGN)
    else $error("ring base low bits not zero");
  chk_fault_stop: assert property ( // RULE15
    bus_fault && bus_master_en |=> !bus_master_en
    && status_word[FBE_BIT] && bus_fault_kind == $past(bus_fault_kind_in))
    else $error("bus fault did not stop master");
  chk_fault_holds: assert property ( // RULE16
    !bus_master_en && !soft_reset_bit |=> !bus_master_en)
    else $error("bus access resumed without reset");
  chk_norm_sum: assert property ( // RULE13
    ev_flags[0] || ev_flags[2] || ev_flags[6] |-> normal_event_summary)
    else $error("normal summary missing");
  chk_abn_sum: assert property ( // RULE14
    fatal_bus_fault || ev_flags[7] |-> abnormal_event_summary)
    else $error("abnormal summary missing");
  chk_flag_sticky: assert property ( // RULE17
    ev_flags[0] && !soft_reset_bit
    && !(do_write && aw_addr == ADDR_DMA_STATUS)
    |=> ev_flags[0])
    else $error("flag dropped without write one");
  chk_state_mirror: assert property ( // RULE11
    aresetn && !soft_reset_bit
    |=> status_word[22:20] == $past(tx_engine_state)
    && status_word[19:17] == $past(rx_engine_state))
    else $error("state field does not follow engine");
  chk_reset_zero: assert property ( // RULE18
    @(posedge aclk) disable iff (1'b0)
    $past(!aresetn) |-> status_word == ZERO32)
    else $error("status not zero after reset");

  cov_tx_kick:  cover property (tx_fetch_req);
  cov_rx_kick:  cover property (rx_fetch_req);
  cov_fault:    cover property (bus_fault && !fatal_bus_fault);
  cov_irq:      cover property ($rose(irq));
endmodule : ldp_dma_front

// >>> src/ldp_pkg.sv
// package: register map, field layout and codes of the dma front end
package ldp_pkg;
  // ==========================================================
  // register byte offsets
  localparam logic [7:0] ADDR_TX_POLL_KICK = 8'h08;
  localparam logic [7:0] ADDR_RX_POLL_KICK = 8'h10;
  localparam logic [7:0] ADDR_RX_RING_BASE = 8'h18;
  localparam logic [7:0] ADDR_TX_RING_BASE = 8'h20;
  localparam logic [7:0] ADDR_DMA_STATUS   = 8'h28;
  localparam logic [7:0] ADDR_INT_MASK     = 8'h38;
  // ==========================================================
  // reset values
  localparam logic [31:0] POLL_RESET = 32'h0fff_ffff;
  localparam logic [31:0] ZERO32     = 32'h0000_0000;
  localparam logic [1:0]  RING_ALIGN = 2'h0;
  // ==========================================================
  // status field positions
  localparam int FLT_LSB = 23;
  localparam int TXS_LSB = 20;
  localparam int RXS_LSB = 17;
  localparam int NSUM_BIT = 16;
  localparam int ASUM_BIT = 15;
  localparam int FBE_BIT  = 13;
  localparam int EV_W     = 12;
  // latched event bits that exist (0-3, 5-9, 11)
  localparam logic [11:0] EV_MASK   = 12'hbef;
  // normal group: bits 0, 2, 6
  localparam logic [11:0] NORM_MASK = 12'h045;
  // abnormal group: bits 1, 3, 5, 7, 8, 9, 11
  localparam logic [11:0] ABN_MASK  = 12'hbaa;
  // ==========================================================
  // axi responses
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  // ==========================================================
  // bus fault kinds
  typedef enum logic [2:0] {
    FLT_PARITY = 3'h0,
    FLT_MABORT = 3'h1,
    FLT_TABORT = 3'h2
  } ldp_fault_e;
  // transmit engine states
  typedef enum logic [2:0] {
    TX_STOP = 3'h0, TX_FETCH = 3'h1, TX_SEND = 3'h2, TX_FILL = 3'h3,
    TX_SUSP = 3'h6, TX_WBACK = 3'h7
  } ldp_tx_e;
  // receive engine states
  typedef enum logic [2:0] {
    RX_STOP = 3'h0, RX_FETCH = 3'h1, RX_CHECK = 3'h2, RX_WAIT = 3'h3,
    RX_SUSP = 3'h4, RX_WDESC = 3'h5, RX_FLUSH = 3'h6, RX_DRAIN = 3'h7
  } ldp_rx_e;
endpackage : ldp_pkg

// >>> verif/ldp_engine_model.sv
// partner model: dma engine state machines seen from the front end
`timescale 1ns/100ps
module ldp_engine_model
  import ldp_pkg::*;
(
  // clock and reset
  input  wire logic       aclk,
  input  wire logic       aresetn,
  // bench control
  input  wire logic       set_en,
  input  wire logic [2:0] tx_set,
  input  wire logic [2:0] rx_set,
  // fetch requests from the front end
  input  wire logic       tx_fetch_req,
  input  wire logic       rx_fetch_req,
  // engine state codes
  output logic [2:0]      tx_engine_state,
  output logic [2:0]      rx_engine_state
);
  // ==========================================================
  // engine states: bench loads them, a fetch wakes the engine
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_engine_state <= TX_STOP;
      rx_engine_state <= RX_STOP;
    end else if (set_en) begin
      tx_engine_state <= tx_set;
      rx_engine_state <= rx_set;
    end else begin
      if (tx_fetch_req) tx_engine_state <= TX_FETCH;
      if (rx_fetch_req) rx_engine_state <= RX_FETCH;
    end
  end
endmodule : ldp_engine_model

// >>> verif/ldp_dma_front_tb_top.sv
// testbench: register bus, poll kicks, status flags and bus faults
`timescale 1ns/100ps
module ldp_dma_front_tb_top
  import ldp_pkg::*;
  ;
  // ==========================================================
  // signals
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, v;
  logic        awready, wready, bvalid, arready, rvalid, set_en;
  logic [1:0]  bresp, rresp, r;
  logic        soft_reset_bit, sec_normal_sum, sec_abnormal_sum, bus_fault;
  logic [2:0]  tx_engine_state, rx_engine_state, bus_fault_kind_in;
  logic [2:0]  tx_set, rx_set;
  logic [11:0] event_pulse;
  logic        tx_fetch_req, rx_fetch_req, bus_master_en, irq;
  logic [29:0] tx_ring_start, rx_ring_start;
  int          n_errors, checked, n_txf, n_rxf;
  // ==========================================================
  // design and engine model
  ldp_dma_front i_ldp_dma_front (.aclk, .aresetn, .awaddr, .awvalid,
    .awready, .wdata, .wstrb(4'hf), .wvalid, .wready, .bresp, .bvalid,
    .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
    .soft_reset_bit, .tx_engine_state, .rx_engine_state, .event_pulse,
    .sec_normal_sum, .sec_abnormal_sum, .bus_fault, .bus_fault_kind_in,
    .tx_fetch_req, .rx_fetch_req, .bus_master_en, .tx_ring_start,
    .rx_ring_start, .irq);
  ldp_engine_model i_ldp_engine_model (.aclk, .aresetn, .set_en, .tx_set,
    .rx_set, .tx_fetch_req, .rx_fetch_req, .tx_engine_state,
    .rx_engine_state);
  // ==========================================================
  // clock and fetch pulse counters (sampled mid-cycle)
  always #20 aclk = ~aclk;
  always @(negedge aclk) begin
    if (tx_fetch_req === 1'b1) n_txf++;
    if (rx_fetch_req === 1'b1) n_rxf++;
  end
  // ==========================================================
  // helpers
  task automatic chk(input string nm, input logic [31:0] seen, exp);
    checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask : cyc
  // axi4-lite write: readiness judged mid-cycle, released after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d,
                    output logic [1:0] rs);
    logic at, wt, bt;
    int   n;
    n = 0;
    bt = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    while (!bt && n < 50) begin
      @(negedge aclk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid;
      rs = bresp;
      @(posedge aclk);
      if (at) awvalid <= 0;
      if (wt) wvalid <= 0;
      if (bt) bready <= 0;
      n++;
    end
    if (!bt) chk("write response", 0, 1);
  endtask : wr
  // axi4-lite read
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] rs);
    logic at, rt;
    int   n;
    n = 0;
    rt = 0;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1;
    rready <= 1;
    while (!rt && n < 50) begin
      @(negedge aclk);
      at = arvalid && arready;
      rt = rvalid;
      d = rdata;
      rs = rresp;
      @(posedge aclk);
      if (at) arvalid <= 0;
      if (rt) rready <= 0;
      n++;
    end
    if (!rt) chk("read response", 0, 1);
  endtask : rd
  task automatic setst(input logic [2:0] t, input logic [2:0] x);
    @(posedge aclk);
    set_en <= 1;
    tx_set <= t;
    rx_set <= x;
    @(posedge aclk);
    set_en <= 0;
    cyc(2);
  endtask : setst
  task automatic pulse(input logic [11:0] ev, input logic sn, sa);
    @(posedge aclk);
    event_pulse <= ev;
    sec_normal_sum <= sn;
    sec_abnormal_sum <= sa;
    @(posedge aclk);
    event_pulse <= 0;
    sec_normal_sum <= 0;
    sec_abnormal_sum <= 0;
    cyc(2);
  endtask : pulse
  task automatic fault(input logic [2:0] k);
    @(posedge aclk);
    bus_fault <= 1;
    bus_fault_kind_in <= k;
    @(posedge aclk);
    bus_fault <= 0;
    cyc(2);
  endtask : fault
  // latched flag: survives a zero write, cleared by writing ones
  task automatic flag(input logic [11:0] ev, input logic sn, sa,
                      input logic [31:0] exp);
    pulse(ev, sn, sa);
    rd(ADDR_DMA_STATUS, v, r);
    chk("status set", v, exp);
    wr(ADDR_DMA_STATUS, ZERO32, r);
    rd(ADDR_DMA_STATUS, v, r);
    chk("status held", v, exp);
    wr(ADDR_DMA_STATUS, 32'hffff_ffff, r);
    rd(ADDR_DMA_STATUS, v, r);
    chk("status cleared", v, ZERO32);
  endtask : flag
  // ==========================================================
  // scenarios
  task automatic t_reset;
    rd(ADDR_TX_POLL_KICK, v, r);
    chk("tx poll reset", v, POLL_RESET);
    rd(ADDR_RX_POLL_KICK, v, r);
    chk("rx poll reset", v, POLL_RESET);
    rd(ADDR_DMA_STATUS, v, r);
    chk("status reset", v, ZERO32);
    chk("irq reset", {31'h0, irq}, 32'h0);
    $display("test reset finished");
  endtask : t_reset
  task automatic t_ring;
    wr(ADDR_RX_RING_BASE, 32'hffff_ffff, r);
    rd(ADDR_RX_RING_BASE, v, r);
    chk("rx base", v, 32'hffff_fffc);
    chk("rx start", {2'h0, rx_ring_start}, 32'h3fff_ffff);
    wr(ADDR_TX_RING_BASE, 32'h1234_5677, r);
    chk("bresp", {30'h0, r}, {30'h0, RESP_OKAY});
    rd(ADDR_TX_RING_BASE, v, r);
    chk("tx base", v, 32'h1234_5674);
    chk("tx start", {2'h0, tx_ring_start}, 32'h048d_159d);
    $display("test ring finished");
  endtask : t_ring
  task automatic t_poll;
    setst(TX_SUSP, RX_STOP);
    n_txf = 0;
    n_rxf = 0;
    wr(ADDR_TX_POLL_KICK, ZERO32, r);
    cyc(1);
    chk("tx fetch", n_txf, 1);
    rd(ADDR_TX_POLL_KICK, v, r);
    chk("tx poll", v, ZERO32);
    wr(ADDR_TX_POLL_KICK, ZERO32, r);
    cyc(1);
    chk("tx fetch awake", n_txf, 1);
    setst(TX_STOP, RX_SUSP);
    wr(ADDR_RX_POLL_KICK, 32'h5a5a_a5a5, r);
    cyc(1);
    chk("rx fetch", n_rxf, 1);
    chk("tx quiet", n_txf, 1);
    setst(TX_STOP, RX_STOP);
    $display("test poll finished");
  endtask : t_poll
  task automatic t_states;
    for (int i = 0; i < 8; i++) begin
      setst(i[2:0], i[2:0]);
      rd(ADDR_DMA_STATUS, v, r);
      chk("tx state", {29'h0, v[22:20]}, i);
      chk("rx state", {29'h0, v[19:17]}, i);
      chk("no flags", {15'h0, v[16:0]}, 32'h0);
    end
    setst(TX_STOP, RX_STOP);
    $display("test states finished");
  endtask : t_states
  task automatic t_flags;
    flag(12'h001, 0, 0, 32'h0001_0001);
    flag(12'h040, 0, 0, 32'h0001_0040);
    flag(12'h800, 0, 0, 32'h0000_8800);
    flag(12'h000, 1, 0, 32'h0001_0000);
    flag(12'h000, 0, 1, 32'h0000_8000);
    flag(12'h010, 0, 0, ZERO32);
    wr(ADDR_INT_MASK, 32'h0000_8000, r);
    pulse(12'h001, 0, 0);
    chk("irq masked", {31'h0, irq}, 32'h0);
    pulse(12'h002, 0, 0);
    chk("irq raised", {31'h0, irq}, 32'h1);
    wr(ADDR_DMA_STATUS, 32'hffff_ffff, r);
    cyc(1);
    chk("irq cleared", {31'h0, irq}, 32'h0);
    $display("test flags finished");
  endtask : t_flags
  task automatic t_fault;
    for (int k = 0; k < 3; k++) begin
      fault(k[2:0]);
      chk("master off", {31'h0, bus_master_en}, 32'h0);
      rd(ADDR_DMA_STATUS, v, r);
      chk("fault", v, {6'h0, k[2:0], 23'h0000a000});
      fault(3'h3 - k[2:0]);
      rd(ADDR_DMA_STATUS, v, r);
      chk("fault kept", v, {6'h0, k[2:0], 23'h0000a000});
      wr(ADDR_DMA_STATUS, 32'h0000_2000, r);
      chk("master held", {31'h0, bus_master_en}, 32'h0);
      rd(ADDR_DMA_STATUS, v, r);
      chk("fatal cleared", v, {6'h0, k[2:0], 23'h00008000});
      @(posedge aclk);
      soft_reset_bit <= 1;
      @(posedge aclk);
      soft_reset_bit <= 0;
      cyc(2);
      chk("master on", {31'h0, bus_master_en}, 32'h1);
      rd(ADDR_DMA_STATUS, v, r);
      chk("fault gone", v, ZERO32);
    end
    rd(8'h30, v, r);
    chk("unmapped rresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    chk("unmapped rdata", v, ZERO32);
    wr(8'h30, 32'h1, r);
    chk("unmapped bresp", {30'h0, r}, {30'h0, RESP_SLVERR});
    $display("test fault finished");
  endtask : t_fault
  // ==========================================================
  // verdict and end of run
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask : test_done
  // watchdog: the whole sequence needs a few hundred cycles
  initial begin
    repeat (20000) @(posedge aclk);
    n_errors++;
    test_done();
  end
  // main sequence
  initial begin
    {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready} = 0;
    {awaddr, araddr, wdata, soft_reset_bit, set_en, tx_set, rx_set} = 0;
    {sec_normal_sum, sec_abnormal_sum, bus_fault, bus_fault_kind_in} = 0;
    event_pulse = 0;
    repeat (8) @(posedge aclk);
    aresetn <= 1;
    t_reset();
    t_ring();
    t_poll();
    t_states();
    t_flags();
    t_fault();
    test_done();
  end
endmodule : ldp_dma_front_tb_top
